// ### design/ebac_top.sv
// Band access control, key selection and inline cipher with APB slave
`timescale 1ns/1ps
module ebac_top #(
   parameter logic [31:0]  MAX_LBA      = 32'hFFFF_FFFF,
   // Arbitrary values, no meaning beyond this block
   parameter logic [255:0] FACTORY_CRED = {8{32'h5A3C_96E1}},
   parameter logic [255:0] WRAP_MASK    = {8{32'hC33C_A55A}}
) (
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Data request port
   input  wire logic        dreq_valid,
   input  wire logic        dreq_write,
   input  wire logic [31:0] dreq_lba,
   input  wire logic [15:0] dreq_count,
   input  wire logic [127:0] dreq_data,
   output logic             dresp_valid,
   output logic             dresp_refused,
   output logic [3:0]       dresp_band,
   output logic [127:0]     dresp_data,
   // Supply loss pin and firmware port state
   input  wire logic        supply_loss_event,
   output logic             fw_download_locked
);
   localparam int NB = ebac_pkg::NUM_BANDS;
   localparam int CW = ebac_pkg::CRED_W;

   //--------------------------------------------------------------
   // State
   //--------------------------------------------------------------
   logic [CW-1:0]  owner_credential, next_owner;
   logic [CW-1:0]  wipe_authority_credential, next_wipe;
   logic [CW-1:0]  per_region_credential [NB];
   logic [CW-1:0]  next_region [NB];
   logic [CW-1:0]  region_content_key [NB];
   logic [CW-1:0]  next_key [NB];
   logic [NB-1:0]  key_ok, next_key_ok;
   logic [31:0]    b_start [NB], next_start [NB];
   logic [31:0]    b_end [NB], next_end [NB];
   logic [NB-1:0]  b_def, next_def, b_en, next_en;
   logic [NB-1:0]  rlock, next_rlock, wlock, next_wlock;
   logic [NB-1:0]  relock_trigger, next_trig;
   logic [NB-1:0]  read_guard_armed, next_rg;
   logic [NB-1:0]  write_guard_armed, next_wg;
   logic           next_fwl;
   ebac_pkg::ebac_res_t res, next_res;
   logic [CW-1:0]  pres_cred, next_pres, new_cred, next_new;
   logic [31:0]    arg_start, next_astart, arg_len, next_alen;
   logic [31:0]    arg_cfg, next_acfg;
   logic [CW-1:0]  hardware_random_source, next_rng;
   localparam int SYNC_N_W = ebac_pkg::SYNC_N;
   logic [SYNC_N_W-1:0] loss_sync;
   logic           loss_lvl, next_loss_lvl, loss_pulse;

   //--------------------------------------------------------------
   // Helpers
   //--------------------------------------------------------------
   function automatic logic [3:0] band_of(input logic [31:0] a);
      logic [3:0] r;
      r = 4'h0;
      for (int i = NB - 1; i >= 1; i--)
         if (b_def[i] && a >= b_start[i] && a <= b_end[i])
            r = 4'(i);
      return r;
   endfunction

   function automatic logic overlaps(input logic [31:0] s,
                                     input logic [31:0] e,
                                     input logic [3:0]  excl);
      logic r;
      r = 1'b0;
      for (int i = 1; i < NB; i++)
         if (b_def[i] && 4'(i) != excl && !(e < b_start[i] ||
             s > b_end[i]))
            r = 1'b1;
      return r;
   endfunction

   function automatic logic [CW-1:0] put_word(input logic [CW-1:0] v,
                                              input logic [2:0]  idx,
                                              input logic [31:0] d);
      logic [CW-1:0] r;
      r = v;
      r[32*idx +: 32] = d;
      return r;
   endfunction

   // Keyed invertible block transform, chained with a per-block IV
   function automatic logic [127:0] blk_enc(input logic [127:0] x,
                                            input logic [255:0] k);
      logic [127:0] t;
      t = x ^ k[127:0];
      return {t[127-ebac_pkg::ROT:0], t[127:128-ebac_pkg::ROT]}
             ^ k[255:128];
   endfunction

   function automatic logic [127:0] blk_dec(input logic [127:0] y,
                                            input logic [255:0] k);
      logic [127:0] t;
      t = y ^ k[255:128];
      return {t[ebac_pkg::ROT-1:0], t[127:ebac_pkg::ROT]} ^ k[127:0];
   endfunction

   //--------------------------------------------------------------
   // APB slave: zero wait, data prepared in setup phase
   //--------------------------------------------------------------
   logic        wr_fire, next_pready, next_pslverr;
   logic [31:0] next_prdata;
   logic        mapped;
   ebac_pkg::ebac_cmd_t cmd;
   logic [3:0]  cband;
   logic        exec;

   assign wr_fire = psel && penable && pready && pwrite;
   assign exec    = wr_fire && paddr == ebac_pkg::OFF_CMD;
   assign cmd     = ebac_pkg::ebac_cmd_t'(pwdata[ebac_pkg::CMD_LSB +: 4]);
   assign cband   = pwdata[ebac_pkg::BAND_LSB +: 4];

   always_comb begin
      next_pready  = psel && !penable;
      next_prdata  = 32'h0000_0000;
      mapped       = 1'b1;
      if (paddr >= ebac_pkg::OFF_FACT &&
          paddr < ebac_pkg::OFF_FACT + 8'h20) begin
         next_prdata = FACTORY_CRED[32*paddr[4:2] +: 32];
      end else if (paddr >= ebac_pkg::OFF_CRED &&
                   paddr < ebac_pkg::OFF_FACT) begin
         next_prdata = 32'h0000_0000;
      end else begin
         case (paddr)
            ebac_pkg::OFF_CMD:    next_prdata = 32'h0000_0000;
            ebac_pkg::OFF_STATUS: next_prdata = {23'h000000,
               fw_download_locked, 5'h00, res};
            ebac_pkg::OFF_RAND:   next_prdata =
               hardware_random_source[31:0];
            ebac_pkg::OFF_LOCKS:  next_prdata = {wlock, rlock};
            ebac_pkg::OFF_START:  next_prdata = arg_start;
            ebac_pkg::OFF_LEN:    next_prdata = arg_len;
            ebac_pkg::OFF_CFG:    next_prdata = arg_cfg;
            ebac_pkg::OFF_BANDS:  next_prdata = {b_en, b_def};
            default:              mapped = 1'b0;
         endcase
      end
      if (!(psel && !penable)) next_prdata = prdata;
      next_pslverr = psel && !penable && !mapped;
      if (!pwrite) begin
         next_astart = arg_start;
      end else begin
         next_astart = arg_start;
      end
      next_alen = arg_len;
      next_acfg = arg_cfg;
      next_pres = pres_cred;
      next_new  = new_cred;
      if (wr_fire) begin
         case (paddr)
            ebac_pkg::OFF_START: next_astart = pwdata;
            ebac_pkg::OFF_LEN:   next_alen   = pwdata;
            ebac_pkg::OFF_CFG:   next_acfg   = pwdata;
            default: begin
               if (paddr >= ebac_pkg::OFF_CRED &&
                   paddr < ebac_pkg::OFF_NEW)
                  next_pres = put_word(pres_cred, paddr[4:2], pwdata);
               else if (paddr >= ebac_pkg::OFF_NEW &&
                        paddr < ebac_pkg::OFF_FACT)
                  next_new = put_word(new_cred, paddr[4:2], pwdata);
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready    <= 1'b0;
         pslverr   <= 1'b0;
         prdata    <= 32'h0000_0000;
         arg_start <= 32'h0000_0000;
         arg_len   <= 32'h0000_0000;
         arg_cfg   <= 32'h0000_0000;
         pres_cred <= '0;
         new_cred  <= '0;
      end else begin
         pready    <= next_pready;
         pslverr   <= next_pslverr;
         prdata    <= next_prdata;
         arg_start <= next_astart;
         arg_len   <= next_alen;
         arg_cfg   <= next_acfg;
         pres_cred <= next_pres;
         new_cred  <= next_new;
      end
   end

   //--------------------------------------------------------------
   // Random source and supply loss synchroniser
   //--------------------------------------------------------------
   always_comb begin
      // 256-bit Fibonacci-style shift; feeds keys and host reads
      next_rng = {hardware_random_source[CW-2:0],
                  hardware_random_source[CW-1] ^
                  hardware_random_source[253] ^
                  hardware_random_source[250] ^
                  hardware_random_source[245]};
      next_loss_lvl = loss_lvl;
      if (loss_sync[1] == loss_sync[2]) next_loss_lvl = loss_sync[2];
      loss_pulse = next_loss_lvl && !loss_lvl;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hardware_random_source <= {8{32'h1F2E_3D4C}};
         loss_sync <= '0;
         loss_lvl  <= 1'b0;
      end else begin
         hardware_random_source <= next_rng;
         loss_sync <= {loss_sync[1:0], supply_loss_event};
         loss_lvl  <= next_loss_lvl;
      end
   end

   //--------------------------------------------------------------
   // Security command execution
   //--------------------------------------------------------------
   logic        admin_ok, owner_ok, wipe_ok, band_ok;
   logic [31:0] def_end;

   assign owner_ok = pres_cred == owner_credential;
   assign admin_ok = owner_ok || pres_cred == FACTORY_CRED;
   assign wipe_ok  = pres_cred == wipe_authority_credential;
   assign band_ok  = pres_cred == per_region_credential[cband] ||
                     wipe_ok;
   assign def_end  = arg_start + arg_len - 32'h0000_0001;

   always_comb begin
      logic filled;
      filled      = 1'b0;
      next_owner  = owner_credential;
      next_wipe   = wipe_authority_credential;
      next_region = per_region_credential;
      next_key    = region_content_key;
      next_key_ok = key_ok;
      next_start  = b_start;
      next_end    = b_end;
      next_def    = b_def;
      next_en     = b_en;
      next_rlock  = rlock;
      next_wlock  = wlock;
      next_trig   = relock_trigger;
      next_rg     = read_guard_armed;
      next_wg     = write_guard_armed;
      next_fwl    = fw_download_locked;
      next_res    = res;
      // Fill missing keys one per cycle, stored wrapped
      // One band per cycle so each band draws a distinct random value
      for (int i = 0; i < NB; i++)
         if (!key_ok[i] && !filled) begin
            next_key[i] = hardware_random_source ^ WRAP_MASK;
            next_key_ok[i] = 1'b1;
            filled = 1'b1;
         end
      if (exec) begin
         next_res = ebac_pkg::RES_OK;
         case (cmd)
            ebac_pkg::CMD_FW_LOCK:
               if (owner_ok) next_fwl = 1'b1;
               else next_res = ebac_pkg::RES_AUTH;
            ebac_pkg::CMD_FW_UNLOCK:
               if (admin_ok) next_fwl = 1'b0;
               else next_res = ebac_pkg::RES_AUTH;
            ebac_pkg::CMD_SET_OWNER:
               if (admin_ok) next_owner = new_cred;
               else next_res = ebac_pkg::RES_AUTH;
            ebac_pkg::CMD_SET_WIPE:
               if (wipe_ok) next_wipe = new_cred;
               else next_res = ebac_pkg::RES_AUTH;
            ebac_pkg::CMD_BAND_ENABLE:
               if (cband < 4'h2) next_res = ebac_pkg::RES_BAD_BAND;
               else if (!wipe_ok) next_res = ebac_pkg::RES_AUTH;
               else next_en[cband] = 1'b1;
            ebac_pkg::CMD_BAND_DEFINE:
               if (cband == 4'h0) next_res = ebac_pkg::RES_BAD_BAND;
               else if (!band_ok) next_res = ebac_pkg::RES_AUTH;
               else if (!b_en[cband])
                  next_res = ebac_pkg::RES_DISABLED;
               else if (arg_len == 32'h0000_0000 ||
                        (arg_start % ebac_pkg::ALIGN_BLKS) != 0 ||
                        (arg_len % ebac_pkg::ALIGN_BLKS) != 0 ||
                        def_end < arg_start || def_end > MAX_LBA)
                  next_res = ebac_pkg::RES_ALIGN;
               else if (overlaps(arg_start, def_end, cband))
                  next_res = ebac_pkg::RES_OVERLAP;
               else begin
                  next_start[cband] = arg_start;
                  next_end[cband]   = def_end;
                  next_def[cband]   = 1'b1;
               end
            ebac_pkg::CMD_BAND_CRED:
               if (band_ok) next_region[cband] = new_cred;
               else next_res = ebac_pkg::RES_AUTH;
            ebac_pkg::CMD_BAND_REKEY:
               if (band_ok) begin
                  // Old key overwritten in place, nothing retained
                  next_key[cband] = hardware_random_source ^
                                    WRAP_MASK;
               end else next_res = ebac_pkg::RES_AUTH;
            ebac_pkg::CMD_LOCK_CFG:
               if (band_ok) begin
                  next_trig[cband] = arg_cfg[ebac_pkg::CFG_TRIG];
                  next_rg[cband]   = arg_cfg[ebac_pkg::CFG_RG];
                  next_wg[cband]   = arg_cfg[ebac_pkg::CFG_WG];
               end else next_res = ebac_pkg::RES_AUTH;
            ebac_pkg::CMD_BAND_UNLOCK:
               if (band_ok) begin
                  next_rlock[cband] = 1'b0;
                  next_wlock[cband] = 1'b0;
               end else next_res = ebac_pkg::RES_AUTH;
            ebac_pkg::CMD_BAND_LOCK:
               if (band_ok) begin
                  next_rlock[cband] = read_guard_armed[cband];
                  next_wlock[cband] = write_guard_armed[cband];
               end else next_res = ebac_pkg::RES_AUTH;
            default: next_res = ebac_pkg::RES_BAD_CMD;
         endcase
      end
      // Relock last: the supply event wins over a same-cycle unlock
      if (loss_pulse)
         for (int i = 0; i < NB; i++)
            if (relock_trigger[i] && read_guard_armed[i] &&
                write_guard_armed[i]) begin
               next_rlock[i] = 1'b1;
               next_wlock[i] = 1'b1;
            end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         owner_credential          <= FACTORY_CRED;
         wipe_authority_credential <= FACTORY_CRED;
         for (int i = 0; i < NB; i++) begin
            per_region_credential[i] <= FACTORY_CRED;
            region_content_key[i]    <= '0;
            b_start[i] <= 32'h0000_0000;
            b_end[i]   <= 32'h0000_0000;
         end
         key_ok  <= '0;
         b_def   <= '0;
         b_en    <= 16'h0003;
         rlock   <= '0;
         wlock   <= '0;
         relock_trigger    <= '0;
         read_guard_armed  <= '0;
         write_guard_armed <= '0;
         fw_download_locked <= 1'b0;
         res     <= ebac_pkg::RES_OK;
      end else begin
         owner_credential          <= next_owner;
         wipe_authority_credential <= next_wipe;
         per_region_credential     <= next_region;
         region_content_key        <= next_key;
         key_ok  <= next_key_ok;
         b_start <= next_start;
         b_end   <= next_end;
         b_def   <= next_def;
         b_en    <= next_en;
         rlock   <= next_rlock;
         wlock   <= next_wlock;
         relock_trigger    <= next_trig;
         read_guard_armed  <= next_rg;
         write_guard_armed <= next_wg;
         fw_download_locked <= next_fwl;
         res     <= next_res;
      end
   end

   //--------------------------------------------------------------
   // Data path: band match, lock check, always-on cipher
   //--------------------------------------------------------------
   logic [31:0]  req_end;
   logic [3:0]   req_band;
   logic         refuse, next_dv, next_ref;
   logic [255:0] k;
   logic [127:0] iv, next_dd;

   assign req_end  = dreq_lba + 32'(dreq_count) - 32'h0000_0001;
   assign req_band = band_of(dreq_lba);

   always_comb begin
      k   = region_content_key[req_band] ^ WRAP_MASK;
      iv  = 128'(dreq_lba) ^ k[255:128];
      refuse = dreq_count == 16'h0000 || req_end < dreq_lba ||
               overlaps(dreq_lba, req_end, req_band) ||
               !key_ok[req_band] ||
               (dreq_write ? wlock[req_band]
                           : rlock[req_band]);
      next_dv  = dreq_valid;
      next_ref = dreq_valid && refuse;
      // No path skips the cipher; refused requests return zero
      if (!dreq_valid || refuse) next_dd = 128'h0;
      else if (dreq_write) next_dd = blk_enc(dreq_data ^ iv, k);
      else next_dd = blk_dec(dreq_data, k) ^ iv;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dresp_valid   <= 1'b0;
         dresp_refused <= 1'b0;
         dresp_band    <= 4'h0;
         dresp_data    <= 128'h0;
      end else begin
         dresp_valid   <= next_dv;
         dresp_refused <= next_ref;
         dresp_band    <= dreq_valid ? req_band : 4'h0;
         dresp_data    <= next_dd;
      end
   end

   //--------------------------------------------------------------
   // Checks
   //--------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   chk_locked_read_refused: assert property (
      dreq_valid && !dreq_write && rlock[req_band] |=> dresp_refused)
      else $error("read to locked band not refused");
   chk_fw_lock_owner: assert property (
      $rose(fw_download_locked) |-> $past(exec) &&
      $past(cmd) == ebac_pkg::CMD_FW_LOCK && $past(owner_ok))
      else $error("firmware port locked without owner credential");
   chk_supply_relock: assert property (
      loss_pulse && relock_trigger[1] && read_guard_armed[1] &&
      write_guard_armed[1] |=> rlock[1] && wlock[1])
      else $error("band 1 not relocked on supply loss");
   chk_no_lock_unarmed: assert property (
      loss_pulse && !exec && !relock_trigger[2] && !rlock[2]
      |=> !rlock[2])
      else $error("band 2 relocked without trigger");
   chk_bad_cred_reject: assert property (
      exec && cmd == ebac_pkg::CMD_SET_OWNER && !admin_ok
      |=> res == ebac_pkg::RES_AUTH && $stable(owner_credential))
      else $error("owner credential changed without authority");
   chk_define_enable: assert property (
      exec && cmd == ebac_pkg::CMD_BAND_DEFINE && cband > 4'h1 &&
      band_ok && !b_en[cband] |=> res == ebac_pkg::RES_DISABLED)
      else $error("disabled band accepted block space");
   chk_define_align: assert property (
      exec && cmd == ebac_pkg::CMD_BAND_DEFINE && b_en[cband] &&
      band_ok && cband != 4'h0 && arg_start[2:0] != 3'h0
      |=> res == ebac_pkg::RES_ALIGN)
      else $error("unaligned band start accepted");
   chk_apb_answer: assert property (
      psel && !penable |=> pready ##1 !pready)
      else $error("APB answer not exactly one access cycle");

   cov_band_define: cover property (
      exec && cmd == ebac_pkg::CMD_BAND_DEFINE ##1
      res == ebac_pkg::RES_OK);
   cov_relock: cover property (loss_pulse ##1 |rlock);
   cov_write_ok: cover property (
      dreq_valid && dreq_write ##1 !dresp_refused);
endmodule

// ### inc/ebac_pkg.sv
// Constants for the encrypted band access control block
//
// Contract
// - Per-port inline cipher encrypts writes, decrypts reads
// - Cipher always active, no bypass control exists
// - Content keys generated internally, never exposed
// - Stored content keys kept only in wrapped form
// - Distinct key per band, selected by block address
// - Security requests without valid credential are rejected
// - Admin provider accepts owner or factory credential
// - Band access by region or wipe credential
// - All credentials ship as readable factory default
// - Hardware random source derives keys, feeds host
// - Supply loss relocks band if trigger, guards set
// - Data requests to locked band are refused
// - Firmware port ships unlocked; owner credential locks it
// - Factory state: only global band 0, all blocks
// - Band 1 defined by start and length
// - Bands 2-15 need wipe-authority enable first
// - Overlapping band definitions rejected; adjacency allowed
// - Band boundaries must be 4KB aligned
// - Band key or credential replaceable when authorised
// - Replaced key overwritten, no history kept
package ebac_pkg;
   localparam int NUM_BANDS  = 16;
   localparam int CRED_W     = 256;
   localparam int LBA_W      = 32;
   localparam int BLK_W      = 128;
   localparam int ROT        = 13;
   localparam int SYNC_N     = 3;
   // 4KB in 512-byte blocks
   localparam logic [31:0] ALIGN_BLKS = 32'h0000_0008;
   // APB byte offsets
   localparam logic [7:0] OFF_CMD    = 8'h00;
   localparam logic [7:0] OFF_STATUS = 8'h04;
   localparam logic [7:0] OFF_RAND   = 8'h08;
   localparam logic [7:0] OFF_LOCKS  = 8'h0C;
   localparam logic [7:0] OFF_START  = 8'h10;
   localparam logic [7:0] OFF_LEN    = 8'h14;
   localparam logic [7:0] OFF_CFG    = 8'h18;
   localparam logic [7:0] OFF_BANDS  = 8'h1C;
   localparam logic [7:0] OFF_CRED   = 8'h20;
   localparam logic [7:0] OFF_NEW    = 8'h40;
   localparam logic [7:0] OFF_FACT   = 8'h60;
   // Command, config and status field positions
   localparam int CMD_LSB  = 0;
   localparam int BAND_LSB = 8;
   localparam int CFG_TRIG = 0;
   localparam int CFG_RG   = 1;
   localparam int CFG_WG   = 2;
   localparam int ST_FWL   = 8;
   typedef enum logic [3:0] {
      CMD_NONE, CMD_FW_LOCK, CMD_FW_UNLOCK, CMD_SET_OWNER,
      CMD_BAND_ENABLE, CMD_BAND_DEFINE, CMD_BAND_CRED, CMD_BAND_REKEY,
      CMD_LOCK_CFG, CMD_BAND_UNLOCK, CMD_BAND_LOCK, CMD_SET_WIPE
   } ebac_cmd_t;
   typedef enum logic [2:0] {
      RES_OK, RES_AUTH, RES_BAD_BAND, RES_DISABLED, RES_ALIGN,
      RES_OVERLAP, RES_BAD_CMD
   } ebac_res_t;
endpackage

// ### verification/ebac_host.sv
// Host initiator model carrying commands over the APB register port
`timescale 1ns/1ps
module ebac_host (
   // APB master side
   input  wire logic        pclk,
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [7:0]       paddr,
   output logic [31:0]      pwdata,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr
);
   logic [31:0] rdata;
   logic        err;
   initial begin
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 8'h00;
      pwdata  = 32'h0000_0000;
   end
   // Waits for pready; the bench watchdog ends a hang
   task automatic xfer(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      rdata = prdata;
      err   = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
endmodule

// ### verification/tb_top.sv
// Self-checking bench for the band access control block
`timescale 1ns/1ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin \
   fails++; $display("wrong value %s exp %0h got %0h", n, e, g); end end
module tb_top;
   // Arbitrary value
   localparam logic [255:0] FC = {8{32'h1B2D_4E87}};
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, dv, dw;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, dl, l;
   logic [15:0] dc;
   logic [127:0] dd, d, c;
   logic rv, rr, fwl, sl;
   logic [3:0] rb;
   logic [127:0] rx;
   int fails, comparisons, seed;
   int unsigned bs[$];
   ebac_top #(.FACTORY_CRED(FC)) u_ebac_top (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .dreq_valid(dv), .dreq_write(dw), .dreq_lba(dl), .dreq_count(dc),
      .dreq_data(dd), .dresp_valid(rv), .dresp_refused(rr),
      .dresp_band(rb), .dresp_data(rx), .supply_loss_event(sl),
      .fw_download_locked(fwl));
   ebac_host u_ebac_host (.pclk(pclk), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr));
   always #50 pclk = ~pclk;
   task automatic rd(input logic [7:0] a);
      u_ebac_host.xfer(1'b0, a, 32'h0000_0000);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      u_ebac_host.xfer(1'b1, a, v);
   endtask
   task automatic cmd(input logic [3:0] op, input logic [3:0] b,
                      input logic [255:0] k, input logic [2:0] e);
      for (int i = 0; i < 8; i++)
         wr(8'(32 + 4 * i), k[32*i+:32]);
      wr(ebac_pkg::OFF_CMD, {20'h0, b, 4'h0, op});
      rd(ebac_pkg::OFF_STATUS);
      `CHK("result", e, u_ebac_host.rdata[2:0])
   endtask
   task automatic dq(input logic w, input logic [31:0] a,
                     input logic [127:0] v);
      @(posedge pclk);
      dv <= 1'b1;
      dw <= w;
      dl <= a;
      dd <= v;
      @(posedge pclk);
      dv <= 1'b0;
      #1;
      `CHK("resp", 1'b1, rv)
   endtask
   function automatic logic [3:0] eb(input int unsigned a);
      eb = 4'h0;
      for (int i = 1; i < bs.size(); i++)
         if (a >= bs[i] && a < bs[i] + 16)
            eb = 4'(i);
   endfunction
   task automatic test_done;
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      #3000000;
      fails++;
      test_done;
   end
   initial begin
      {pclk, presetn, dv, dw, dl, dd, sl} = '0;
      dc = 16'h0001;
      seed = 4947;
      bs = '{0};
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      repeat (20) @(posedge pclk);
      rd(ebac_pkg::OFF_BANDS);
      `CHK("bands", 32'h0003_0000, u_ebac_host.rdata)
      rd(ebac_pkg::OFF_FACT);
      `CHK("factory", FC[31:0], u_ebac_host.rdata)
      rd(8'h80);
      `CHK("unmapped", 1'b1, u_ebac_host.err)
      `CHK("fw", 1'b0, fwl)
      rd(ebac_pkg::OFF_RAND);
      l = u_ebac_host.rdata;
      rd(ebac_pkg::OFF_RAND);
      `CHK("random", 1'b1, u_ebac_host.rdata !== l)
      l = {4'h8, 28'($random(seed))};
      d = {$random(seed), $random(seed), $random(seed), $random(seed)};
      dq(1'b1, l, d);
      c = rx;
      `CHK("band", 5'h00, {rr, rb})
      `CHK("cipher", 1'b1, c !== d)
      dq(1'b0, l, c);
      `CHK("plain", d, rx)
      cmd(ebac_pkg::CMD_FW_LOCK, 4'h0, ~FC, ebac_pkg::RES_AUTH);
      cmd(ebac_pkg::CMD_FW_LOCK, 4'h0, FC, ebac_pkg::RES_OK);
      cmd(ebac_pkg::CMD_SET_OWNER, 4'h0, ~FC, ebac_pkg::RES_AUTH);
      cmd(ebac_pkg::CMD_FW_UNLOCK, 4'h0, ~FC, ebac_pkg::RES_AUTH);
      `CHK("fw", 1'b1, fwl)
      wr(ebac_pkg::OFF_START, 32'h0000_0104);
      wr(ebac_pkg::OFF_LEN, 32'h0000_0010);
      cmd(ebac_pkg::CMD_BAND_DEFINE, 4'h1, FC, ebac_pkg::RES_ALIGN);
      wr(ebac_pkg::OFF_START, 32'h0000_0100);
      cmd(ebac_pkg::CMD_BAND_DEFINE, 4'h1, FC, ebac_pkg::RES_OK);
      wr(ebac_pkg::OFF_START, 32'h0000_0108);
      cmd(ebac_pkg::CMD_BAND_DEFINE, 4'h2, FC, ebac_pkg::RES_DISABLED);
      cmd(ebac_pkg::CMD_BAND_ENABLE, 4'h2, FC, ebac_pkg::RES_OK);
      cmd(ebac_pkg::CMD_BAND_DEFINE, 4'h2, FC, ebac_pkg::RES_OVERLAP);
      wr(ebac_pkg::OFF_START, 32'h0000_0110);
      cmd(ebac_pkg::CMD_BAND_DEFINE, 4'h2, FC, ebac_pkg::RES_OK);
      bs = '{0, 'h100, 'h110};
      foreach (bs[i]) begin
         dq(1'b0, 32'(bs[i] + 15), d);
         `CHK("band", eb(bs[i] + 15), rb)
      end
      wr(ebac_pkg::OFF_CFG, 32'h0000_0007);
      cmd(ebac_pkg::CMD_LOCK_CFG, 4'h1, FC, ebac_pkg::RES_OK);
      cmd(ebac_pkg::CMD_BAND_LOCK, 4'h1, FC, ebac_pkg::RES_OK);
      dq(1'b0, 32'h0000_0100, d);
      `CHK("locked", {1'b1, 128'h0}, {rr, rx})
      cmd(ebac_pkg::CMD_BAND_UNLOCK, 4'h1, FC, ebac_pkg::RES_OK);
      dq(1'b1, 32'h0000_0100, d);
      c = rx;
      `CHK("open", 1'b0, rr)
      cmd(ebac_pkg::CMD_BAND_REKEY, 4'h1, FC, ebac_pkg::RES_OK);
      dq(1'b0, 32'h0000_0100, c);
      `CHK("old key", 1'b1, rx !== d)
      sl <= 1'b1;
      repeat (6) @(posedge pclk);
      rd(ebac_pkg::OFF_LOCKS);
      `CHK("relock", 32'h0002_0002, u_ebac_host.rdata)
      test_done;
   end
endmodule
